// *** core/program_memory_code_protection.sv ***
// Access gating and protection-bit storage for program flash and data EEPROM.
`timescale 1ns/100ps
module program_memory_code_protection
    import code_protect_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rst,
    input wire code_protect_pkg::mem_size_t memSize,
    // CPU table access
    input wire logic tblRead,
    input wire logic tblWrite,
    input wire logic [code_protect_pkg::ADDR_W-1:0] tblAddr,
    input wire logic [code_protect_pkg::ADDR_W-1:0] instrAddr,
    input wire logic [7:0] tblWdata,
    input wire logic [7:0] flashRdata,
    output logic [7:0] tblRdata,
    output logic tblDone,
    output logic flashWrite,
    output logic [code_protect_pkg::ADDR_W-1:0] flashAddr,
    output logic [7:0] flashWdata,
    // CPU data EEPROM
    input wire logic eeCpuWrite,
    output logic eeCpuWriteOk,
    // External programmer
    input wire code_protect_pkg::prog_op_t progOp,
    input wire logic progEeSel,
    input wire logic progChipErase,
    input wire logic [code_protect_pkg::ADDR_W-1:0] progAddr,
    input wire logic [7:0] progWdata,
    output logic [7:0] progRdata,
    output logic progDone,
    output logic progRefused
);
    import code_protect_pkg::*;

    logic [7:0] cpBits_r, cpBits_nxt, wpBits_r, wpBits_nxt, trpBits_r, trpBits_nxt;
    logic [7:0] eeCp_r, eeCp_nxt, eeWp_r, eeWp_nxt, bootTrp_r, bootTrp_nxt;
    logic [7:0] bootCfg_r, bootCfg_nxt;
    logic [7:0] tblRdata_r, tblRdata_nxt, progRdata_r, progRdata_nxt;
    logic [7:0] flashWdata_r, flashWdata_nxt;
    logic [21:0] flashAddr_r, flashAddr_nxt;
    logic tblDone_r, tblDone_nxt, flashWrite_r, flashWrite_nxt;
    logic eeOk_r, eeOk_nxt, progDone_r, progDone_nxt, progRef_r, progRef_nxt;

    logic tgtBoot, tgtImpl, srcBoot, srcImpl, prgBoot, prgImpl;
    logic [2:0] tgtIdx, srcIdx, prgIdx;

    block_locator targetLoc (
        .addr(tblAddr), .bootSize(bootCfg_r[BOOT_SIZE_LSB+1:BOOT_SIZE_LSB]),
        .memSize(memSize), .inBoot(tgtBoot), .blockIdx(tgtIdx), .implemented(tgtImpl)
    );
    block_locator sourceLoc (
        .addr(instrAddr), .bootSize(bootCfg_r[BOOT_SIZE_LSB+1:BOOT_SIZE_LSB]),
        .memSize(memSize), .inBoot(srcBoot), .blockIdx(srcIdx), .implemented(srcImpl)
    );
    block_locator progLoc (
        .addr(progAddr), .bootSize(bootCfg_r[BOOT_SIZE_LSB+1:BOOT_SIZE_LSB]),
        .memSize(memSize), .inBoot(prgBoot), .blockIdx(prgIdx), .implemented(prgImpl)
    );

    // Per-block protection views, including the boot region.
    logic tgtWp, tgtTrp, prgCp, sameBlock, tgtIsCfg, prgIsCfg, tblCanRead;
    always_comb begin
        tgtWp = tgtBoot ? eeWp_r[BIT_BOOT] : wpBits_r[tgtIdx];
        tgtTrp = tgtBoot ? bootTrp_r[BIT_BOOT] : trpBits_r[tgtIdx];
        prgCp = prgBoot ? eeCp_r[BIT_BOOT] : cpBits_r[prgIdx];
        sameBlock = (tgtBoot == srcBoot) && (tgtBoot || (tgtIdx == srcIdx));
        tgtIsCfg = tblAddr >= CFG_BASE;
        prgIsCfg = progAddr >= CFG_BASE;
        tblCanRead = tgtImpl && (tgtTrp || sameBlock);
    end

    // Reads a configuration byte; also used by the programmer.
    function automatic logic [7:0] cfgRead(input logic [21:0] a, input logic [7:0] cp,
            input logic [7:0] ecp, input logic [7:0] wp, input logic [7:0] ewp,
            input logic [7:0] trp, input logic [7:0] btrp, input logic [7:0] bcfg);
        logic [7:0] v;
        v = 8'h00;
        unique case (a)
            CFG_BLK_CP: v = cp;
            CFG_EE_BOOT_CP: v = ecp & 8'hc0;
            CFG_BLK_WP: v = wp;
            CFG_EE_BOOT_CFG_WP: v = ewp & 8'he0;
            CFG_BLK_TRP: v = trp;
            CFG_BOOT_TRP: v = btrp & 8'h40;
            CFG_BOOT_SIZE: v = bcfg;
            DEV_ID_ADDR: v = DEV_ID_LO;
            default: v = (a == DEV_ID_ADDR + 22'h000001) ? DEV_ID_HI : 8'h00;
        endcase
        return v;
    endfunction

    always_comb begin
        cpBits_nxt = cpBits_r;
        wpBits_nxt = wpBits_r;
        trpBits_nxt = trpBits_r;
        eeCp_nxt = eeCp_r;
        eeWp_nxt = eeWp_r;
        bootTrp_nxt = bootTrp_r;
        bootCfg_nxt = bootCfg_r;
        tblRdata_nxt = tblRdata_r;
        progRdata_nxt = progRdata_r;
        flashWdata_nxt = flashWdata_r;
        flashAddr_nxt = flashAddr_r;
        tblDone_nxt = 1'b0;
        flashWrite_nxt = 1'b0;
        progDone_nxt = 1'b0;
        progRef_nxt = 1'b0;
        eeOk_nxt = eeCpuWrite && eeWp_r[BIT_EE];

        if (tblRead) begin
            tblDone_nxt = 1'b1;
            if (tgtIsCfg) begin
                tblRdata_nxt = cfgRead(tblAddr, cpBits_r, eeCp_r, wpBits_r, eeWp_r,
                    trpBits_r, bootTrp_r, bootCfg_r);
            end else begin
                tblRdata_nxt = tblCanRead ? flashRdata : 8'h00;
            end
        end else if (tblWrite) begin
            tblDone_nxt = 1'b1;
            if (tgtIsCfg) begin
                // Protection bits are AND-ed so they can only be cleared.
                if (eeWp_r[BIT_CFG]) begin
                    unique case (tblAddr)
                        CFG_BLK_CP: cpBits_nxt = cpBits_r & tblWdata;
                        CFG_EE_BOOT_CP: eeCp_nxt = eeCp_r & (tblWdata | 8'h3f);
                        CFG_BLK_WP: wpBits_nxt = wpBits_r & tblWdata;
                        // The config write-protect bit is held out of CPU reach.
                        CFG_EE_BOOT_CFG_WP: eeWp_nxt = eeWp_r & (tblWdata | 8'h3f);
                        CFG_BLK_TRP: trpBits_nxt = trpBits_r & tblWdata;
                        CFG_BOOT_TRP: bootTrp_nxt = bootTrp_r & (tblWdata | 8'hbf);
                        CFG_BOOT_SIZE: bootCfg_nxt = tblWdata;
                        default: ;
                    endcase
                end
            end else if (tgtImpl && tgtWp) begin
                flashWrite_nxt = 1'b1;
                flashAddr_nxt = tblAddr;
                flashWdata_nxt = tblWdata;
            end
        end

        unique case (progOp)
            OP_NONE: ;
            OP_READ: begin
                progDone_nxt = 1'b1;
                if (progEeSel) begin
                    progRef_nxt = !eeCp_r[BIT_EE];
                    progRdata_nxt = eeCp_r[BIT_EE] ? flashRdata : 8'h00;
                end else if (prgIsCfg) begin
                    progRdata_nxt = cfgRead(progAddr, cpBits_r, eeCp_r, wpBits_r, eeWp_r,
                        trpBits_r, bootTrp_r, bootCfg_r);
                end else begin
                    progRef_nxt = !prgCp;
                    progRdata_nxt = (prgCp && prgImpl) ? flashRdata : 8'h00;
                end
            end
            OP_WRITE: begin
                progDone_nxt = 1'b1;
                if (progEeSel) begin
                    progRef_nxt = !(eeCp_r[BIT_EE] && eeWp_r[BIT_EE]);
                end else if (prgIsCfg) begin
                    unique case (progAddr)
                        CFG_BLK_CP: cpBits_nxt = cpBits_r & progWdata;
                        CFG_EE_BOOT_CP: eeCp_nxt = eeCp_r & progWdata;
                        CFG_BLK_WP: wpBits_nxt = wpBits_r & progWdata;
                        CFG_EE_BOOT_CFG_WP: eeWp_nxt = eeWp_r & progWdata;
                        CFG_BLK_TRP: trpBits_nxt = trpBits_r & progWdata;
                        CFG_BOOT_TRP: bootTrp_nxt = bootTrp_r & progWdata;
                        CFG_BOOT_SIZE: bootCfg_nxt = progWdata;
                        default: ;
                    endcase
                end else if (prgCp && prgImpl) begin
                    flashWrite_nxt = 1'b1;
                    flashAddr_nxt = progAddr;
                    flashWdata_nxt = progWdata;
                end else begin
                    progRef_nxt = 1'b1;
                end
            end
            OP_ERASE: begin
                progDone_nxt = 1'b1;
                if (progChipErase) begin
                    cpBits_nxt = ERASED;
                    wpBits_nxt = ERASED;
                    trpBits_nxt = ERASED;
                    eeCp_nxt = ERASED;
                    eeWp_nxt = ERASED;
                    bootTrp_nxt = ERASED;
                end else if (prgBoot) begin
                    eeCp_nxt[BIT_BOOT] = 1'b1;
                    eeWp_nxt[BIT_BOOT] = 1'b1;
                    bootTrp_nxt[BIT_BOOT] = 1'b1;
                end else begin
                    cpBits_nxt[prgIdx] = 1'b1;
                    wpBits_nxt[prgIdx] = 1'b1;
                    trpBits_nxt[prgIdx] = 1'b1;
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys) begin
        if (rst) begin
            // Bits model non-volatile cells; reset leaves them erased until loaded.
            cpBits_r <= ERASED;
            wpBits_r <= ERASED;
            trpBits_r <= ERASED;
            eeCp_r <= ERASED;
            eeWp_r <= ERASED;
            bootTrp_r <= ERASED;
            bootCfg_r <= ERASED;
            tblRdata_r <= 8'h00;
            progRdata_r <= 8'h00;
            flashWdata_r <= 8'h00;
            flashAddr_r <= 22'h000000;
            tblDone_r <= 1'b0;
            flashWrite_r <= 1'b0;
            eeOk_r <= 1'b0;
            progDone_r <= 1'b0;
            progRef_r <= 1'b0;
        end else begin
            cpBits_r <= cpBits_nxt;
            wpBits_r <= wpBits_nxt;
            trpBits_r <= trpBits_nxt;
            eeCp_r <= eeCp_nxt;
            eeWp_r <= eeWp_nxt;
            bootTrp_r <= bootTrp_nxt;
            bootCfg_r <= bootCfg_nxt;
            tblRdata_r <= tblRdata_nxt;
            progRdata_r <= progRdata_nxt;
            flashWdata_r <= flashWdata_nxt;
            flashAddr_r <= flashAddr_nxt;
            tblDone_r <= tblDone_nxt;
            flashWrite_r <= flashWrite_nxt;
            eeOk_r <= eeOk_nxt;
            progDone_r <= progDone_nxt;
            progRef_r <= progRef_nxt;
        end
    end

    assign tblRdata = tblRdata_r;
    assign tblDone = tblDone_r;
    assign flashWrite = flashWrite_r;
    assign flashAddr = flashAddr_r;
    assign flashWdata = flashWdata_r;
    assign eeCpuWriteOk = eeOk_r;
    assign progRdata = progRdata_r;
    assign progDone = progDone_r;
    assign progRefused = progRef_r;
endmodule

// *** core/code_protect_pkg.sv ***
// Constants and types for the program memory code protection block.
package code_protect_pkg;
    localparam int ADDR_W = 22;
    localparam int NUM_BLK = 8;
    localparam logic [21:0] CFG_BLK_CP = 22'h300008;
    localparam logic [21:0] CFG_EE_BOOT_CP = 22'h300009;
    localparam logic [21:0] CFG_BLK_WP = 22'h30000a;
    localparam logic [21:0] CFG_EE_BOOT_CFG_WP = 22'h30000b;
    localparam logic [21:0] CFG_BLK_TRP = 22'h30000c;
    localparam logic [21:0] CFG_BOOT_TRP = 22'h30000d;
    localparam logic [21:0] CFG_BOOT_SIZE = 22'h300006;
    localparam logic [21:0] DEV_ID_ADDR = 22'h3ffffe;
    localparam logic [21:0] CFG_BASE = 22'h300000;
    localparam logic [21:0] BOOT_END_2K = 22'h0007ff;
    localparam logic [21:0] BOOT_END_4K = 22'h000fff;
    localparam logic [21:0] BOOT_END_8K = 22'h001fff;
    localparam int BLK_SHIFT = 14;
    localparam int BOOT_SIZE_LSB = 4;
    localparam int BIT_EE = 7;
    localparam int BIT_BOOT = 6;
    localparam int BIT_CFG = 5;
    localparam logic [7:0] ERASED = 8'hff;
    localparam logic [7:0] DEV_ID_LO = 8'h5a;
    localparam logic [7:0] DEV_ID_HI = 8'ha5;
    typedef enum logic [1:0] {MEM_48K, MEM_64K, MEM_96K, MEM_128K} mem_size_t;
    typedef enum logic [1:0] {OP_NONE, OP_READ, OP_WRITE, OP_ERASE} prog_op_t;
endpackage

// *** core/block_locator.sv ***
// Maps a program address to its protection block index.
`timescale 1ns/100ps
module block_locator
    import code_protect_pkg::*;
(
    // Address and boot size
    input wire logic [code_protect_pkg::ADDR_W-1:0] addr,
    input wire logic [1:0] bootSize,
    input wire code_protect_pkg::mem_size_t memSize,
    // Result
    output logic inBoot,
    output logic [2:0] blockIdx,
    output logic implemented
);
    logic [21:0] bootEnd;
    logic [21:0] memEnd;

    always_comb begin
        unique case (bootSize)
            2'b00: bootEnd = BOOT_END_2K;
            2'b01: bootEnd = BOOT_END_4K;
            default: bootEnd = BOOT_END_8K;
        endcase
        unique case (memSize)
            MEM_48K: memEnd = 22'h00bfff;
            MEM_64K: memEnd = 22'h00ffff;
            MEM_96K: memEnd = 22'h017fff;
            MEM_128K: memEnd = 22'h01ffff;
        endcase
        inBoot = addr <= bootEnd;
        blockIdx = addr[BLK_SHIFT+2:BLK_SHIFT];
        implemented = addr <= memEnd;
    end
endmodule

// *** bench/flash_array_model.sv ***
// Flash array stand-in that answers reads at once and keeps written bytes.
`timescale 1ns/100ps
module flash_array_model (
    // Write port
    input wire logic clk_sys,
    input wire logic flashWrite,
    input wire logic [21:0] flashAddr,
    input wire logic [7:0] flashWdata,
    // Read port
    input wire logic [21:0] rdAddr,
    output logic [7:0] rdData
);
    // A fixed array covers the largest program memory; writes beyond it are dropped.
    bit [7:0] mem [0:131071];
    bit used [0:131071];
    // Unwritten cells show a pattern of the two low address bytes, so a wrong address reads as a match only if its pattern agrees.
    always_comb begin
        rdData = (rdAddr < 22'h020000 && used[rdAddr[16:0]]) ? mem[rdAddr[16:0]] :
            (rdAddr[7:0] ^ rdAddr[15:8] ^ 8'h3c);
    end
    always @(posedge clk_sys) begin
        if (flashWrite && flashAddr < 22'h020000) begin
            mem[flashAddr[16:0]] <= flashWdata;
            used[flashAddr[16:0]] <= 1'b1;
        end
    end
endmodule

// *** bench/program_memory_code_protection_asserts.sv ***
// Port checker for the code protection block.
`timescale 1ns/100ps
module program_memory_code_protection_asserts
    import code_protect_pkg::*;
(
    // System
    input wire logic clk_sys,
    input wire logic rst,
    input wire code_protect_pkg::mem_size_t memSize,
    // CPU side
    input wire logic tblRead,
    input wire logic tblWrite,
    input wire logic [code_protect_pkg::ADDR_W-1:0] tblAddr,
    input wire logic [code_protect_pkg::ADDR_W-1:0] instrAddr,
    input wire logic [7:0] tblWdata,
    input wire logic [7:0] flashRdata,
    input wire logic [7:0] tblRdata,
    input wire logic tblDone,
    input wire logic flashWrite,
    input wire logic [code_protect_pkg::ADDR_W-1:0] flashAddr,
    input wire logic [7:0] flashWdata,
    input wire logic eeCpuWrite,
    input wire logic eeCpuWriteOk,
    // Programmer side
    input wire code_protect_pkg::prog_op_t progOp,
    input wire logic [7:0] progRdata,
    input wire logic progDone,
    input wire logic progRefused
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    AST_TBL_DONE: assert property ((tblRead || tblWrite) |=> tblDone)
        else $error("table access not acknowledged");
    AST_DONE_CAUSE: assert property (tblDone |-> $past(tblRead || tblWrite))
        else $error("table done without request");
    AST_PROG_DONE: assert property ((progOp != OP_NONE) |=> progDone)
        else $error("programmer request not acknowledged");
    AST_REFUSE_ZERO: assert property (progRefused |-> progDone
        && ($past(progOp) != OP_READ || progRdata == 8'h00))
        else $error("refused access leaked data");
    AST_WR_CAUSE: assert property (flashWrite |-> $past(tblWrite && !tblRead)
        || $past(progOp) == OP_WRITE) else $error("flash write without write request");
    AST_WR_DATA: assert property (flashWrite && $past(progOp) != OP_WRITE
        |-> flashAddr == $past(tblAddr) && flashWdata == $past(tblWdata))
        else $error("flash write address or data wrong");
    AST_EE_CAUSE: assert property (eeCpuWriteOk |-> $past(eeCpuWrite))
        else $error("eeprom write granted without request");
    AST_SAME_ADDR: assert property (tblRead && tblAddr == instrAddr && tblAddr < 22'h00c000
        |=> tblRdata == $past(flashRdata)) else $error("in-block read not returned");
    AST_BEYOND: assert property (tblRead && memSize == MEM_48K && tblAddr >= 22'h00c000
        && tblAddr <= 22'h01ffff |=> tblRdata == 8'h00) else $error("unimplemented not zero");
    COV_WR: cover property (flashWrite);
    COV_REF: cover property (progRefused);
    COV_EE: cover property (eeCpuWriteOk);
endmodule
bind program_memory_code_protection program_memory_code_protection_asserts i_asserts (.clk_sys,
    .rst, .memSize, .tblRead, .tblWrite, .tblAddr, .instrAddr, .tblWdata, .flashRdata,
    .tblRdata, .tblDone, .flashWrite, .flashAddr, .flashWdata, .eeCpuWrite, .eeCpuWriteOk,
    .progOp, .progRdata, .progDone, .progRefused);

// *** bench/program_memory_code_protection_tb_top.sv ***
// Self-checking bench for the program memory code protection block.
`timescale 1ns/100ps
`define CHK(nm, e, a) begin checks++; if ((a) !== (e)) begin miscompares++; \
    $display("[ERR] %s expected %h seen %h", nm, e, a); end end
module program_memory_code_protection_tb_top;
    import code_protect_pkg::*;
    logic clk_sys, rst, tblRead, tblWrite, eeCpuWrite, progEeSel, progChipErase, bootTrp;
    logic tblDone, flashWrite, eeCpuWriteOk, progDone, progRefused;
    logic [21:0] tblAddr, instrAddr, progAddr, rdAddr, flashAddr, ta, ia;
    logic [7:0] tblWdata, progWdata, flashRdata, tblRdata, flashWdata, progRdata, trp;
    mem_size_t memSize;
    prog_op_t progOp;
    int miscompares, checks;
    // The array answers at whichever address the active requester presents.
    assign rdAddr = (progOp != OP_NONE) ? progAddr : tblAddr;
    program_memory_code_protection i_program_memory_code_protection (.clk_sys, .rst, .memSize,
        .tblRead, .tblWrite, .tblAddr, .instrAddr, .tblWdata, .flashRdata, .tblRdata, .tblDone,
        .flashWrite, .flashAddr, .flashWdata, .eeCpuWrite, .eeCpuWriteOk, .progOp, .progEeSel,
        .progChipErase, .progAddr, .progWdata, .progRdata, .progDone, .progRefused);
    flash_array_model i_flash_array_model (.clk_sys, .flashWrite, .flashAddr, .flashWdata,
        .rdAddr, .rdData(flashRdata));
    function automatic logic [7:0] pat(input logic [21:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3c;
    endfunction
    function automatic logic [3:0] blk(input logic [21:0] a);
        return (a <= BOOT_END_8K) ? 4'h8 : {1'b0, a[16:14]};
    endfunction
    function automatic logic [7:0] expRd(input logic [21:0] a, input logic [21:0] i);
        logic prot;
        prot = (blk(a) == 4'h8) ? bootTrp : trp[blk(a)];
        return (prot == 1'b0 && blk(a) != blk(i)) ? 8'h00 : pat(a);
    endfunction
    task automatic tbl(input logic w, input logic [21:0] a, input logic [21:0] i,
        input logic [7:0] d);
        @(posedge clk_sys);
        tblRead <= !w;
        tblWrite <= w;
        tblAddr <= a;
        instrAddr <= i;
        tblWdata <= d;
        @(posedge clk_sys);
        tblRead <= 1'b0;
        tblWrite <= 1'b0;
        #1;
        `CHK("tblDone", 1'b1, tblDone)
    endtask
    task automatic prog(input prog_op_t op, input logic eeSel, input logic chip,
        input logic [21:0] a, input logic refused);
        @(posedge clk_sys);
        progOp <= op;
        progEeSel <= eeSel;
        progChipErase <= chip;
        progAddr <= a;
        progWdata <= 8'h00;
        @(posedge clk_sys);
        progOp <= OP_NONE;
        #1;
        `CHK("progRefused", refused, progRefused)
        `CHK("progDone", 1'b1, progDone)
    endtask
    task automatic ee(input logic ok);
        @(posedge clk_sys);
        eeCpuWrite <= 1'b1;
        @(posedge clk_sys);
        eeCpuWrite <= 1'b0;
        #1;
        `CHK("eeCpuWriteOk", ok, eeCpuWriteOk)
    endtask
    task automatic stop_test;
        $display("checks %0d miscompares %0d", checks, miscompares);
        if (miscompares == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        miscompares++;
        stop_test();
    end
    initial begin
        {rst, tblRead, tblWrite, eeCpuWrite, progEeSel, progChipErase} = 6'h20;
        {tblAddr, instrAddr, progAddr, tblWdata, progWdata} = '0;
        progOp = OP_NONE;
        memSize = MEM_48K;
        trp = 8'hfa;
        bootTrp = 1'b0;
        void'($urandom(13));
        repeat (10) @(posedge clk_sys);
        rst <= 1'b0;
        tbl(0, CFG_BLK_WP, 22'h000100, 8'h00);
        `CHK("wpReset", ERASED, tblRdata)
        tbl(0, DEV_ID_ADDR, 22'h000100, 8'h00);
        `CHK("devId", DEV_ID_LO, tblRdata)
        tbl(1, CFG_BLK_CP, 22'h000100, 8'hfe);
        tbl(1, CFG_BLK_CP, 22'h000100, 8'hff);
        tbl(0, CFG_BLK_CP, 22'h000100, 8'h00);
        `CHK("cpOneWay", 8'hfe, tblRdata)
        $display("test config done");
        prog(OP_READ, 0, 0, 22'h002100, 1'b1);
        prog(OP_READ, 0, 0, 22'h004100, 1'b0);
        `CHK("progRdata", pat(22'h004100), progRdata)
        prog(OP_WRITE, 0, 0, 22'h002100, 1'b1);
        tbl(0, 22'h002100, 22'h002000, 8'h00);
        `CHK("cpuIgnoresCp", pat(22'h002100), tblRdata)
        tbl(1, CFG_BLK_WP, 22'h000100, 8'hfd);
        tbl(1, 22'h004010, 22'h000100, 8'h11);
        `CHK("wpBlocked", 1'b0, flashWrite)
        tbl(1, 22'h008010, 22'h000100, pat(22'h008010));
        `CHK("wpOpen", 1'b1, flashWrite)
        $display("test write protect done");
        tbl(1, CFG_BLK_TRP, 22'h000100, trp);
        tbl(1, CFG_BOOT_TRP, 22'h000100, 8'hbf);
        repeat (200) begin
            ta = 22'($urandom % 32'h0000c000);
            ia = ($urandom % 4 == 0) ? ta : 22'($urandom % 32'h0000c000);
            tbl(0, ta, ia, 8'h00);
            `CHK("tblRead", expRd(ta, ia), tblRdata)
        end
        tbl(0, 22'h00c000, 22'h00c000, 8'h00);
        `CHK("beyondSize", 8'h00, tblRdata)
        tbl(1, CFG_BOOT_SIZE, 22'h000100, 8'hcf);
        tbl(0, 22'h000900, 22'h000100, 8'h00);
        `CHK("boot2k", 8'h00, tblRdata)
        tbl(1, CFG_BOOT_SIZE, 22'h000100, 8'hdf);
        tbl(0, 22'h000900, 22'h000100, 8'h00);
        `CHK("boot4k", pat(22'h000900), tblRdata)
        $display("test read protect done");
        ee(1'b1);
        prog(OP_READ, 1, 0, 22'h000010, 1'b0);
        tbl(1, CFG_EE_BOOT_CP, 22'h000100, 8'h7f);
        prog(OP_READ, 1, 0, 22'h000010, 1'b1);
        tbl(1, CFG_EE_BOOT_CFG_WP, 22'h000100, 8'h4f);
        ee(1'b0);
        prog(OP_WRITE, 1, 0, 22'h000010, 1'b1);
        tbl(0, CFG_EE_BOOT_CFG_WP, 22'h000100, 8'h00);
        `CHK("cfgWpFixed", 8'h20, tblRdata & 8'h20)
        $display("test eeprom done");
        prog(OP_ERASE, 0, 0, 22'h004100, 1'b0);
        tbl(0, CFG_BLK_WP, 22'h000100, 8'h00);
        `CHK("blkErase", ERASED, tblRdata)
        prog(OP_WRITE, 0, 0, 22'h008020, 1'b0);
        `CHK("progFlashWr", 1'b1, flashWrite)
        prog(OP_ERASE, 0, 1, 22'h000000, 1'b0);
        tbl(0, CFG_BLK_TRP, 22'h000100, 8'h00);
        `CHK("eraseSets", ERASED, tblRdata)
        $display("test erase done");
        prog(OP_WRITE, 0, 0, CFG_EE_BOOT_CFG_WP, 1'b0);
        tbl(0, CFG_EE_BOOT_CFG_WP, 22'h000100, 8'h00);
        `CHK("progCfgWp", 8'h00, tblRdata)
        tbl(1, CFG_BLK_CP, 22'h000100, 8'h00);
        tbl(0, CFG_BLK_CP, 22'h000100, 8'h00);
        `CHK("cfgLocked", ERASED, tblRdata)
        tbl(1, 22'h000100, 22'h000100, 8'h00);
        `CHK("bootWp", 1'b0, flashWrite)
        memSize <= MEM_128K;
        tbl(0, 22'h01c010, 22'h01c010, 8'h00);
        `CHK("size128", pat(22'h01c010), tblRdata)
        memSize <= MEM_64K;
        tbl(0, 22'h010000, 22'h010000, 8'h00);
        `CHK("size64", 8'h00, tblRdata)
        $display("test lock and size done");
        stop_test();
    end
endmodule
